// *** logic/sleep_wake_reset_watchdog.sv ***
// Power-on delay, light/deep sleep, deep-sleep recovery and window-locked watchdog control
//
// The plain strobed port was left to the implementer.
`include "sleep_wake_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module sleep_wake_reset_watchdog #(
	parameter int unsigned POR_CYCLES  = `SW_POR_DELAY_US * `SW_MCLK_MHZ,
	parameter int unsigned WDT_BASE    = `SW_WDT_BASE_CYCLES,
	parameter int unsigned POR_CNT_W   = 20
) (
	input  wire logic                    i_mclk,         // System clock, 250 MHz
	input  wire logic                    i_resetn,       // Async reset, active low
	input  wire logic [7:0]              i_addr,         // Register address
	input  wire logic [7:0]              i_wdata,        // Register write data
	input  wire logic                    i_wr,           // Write strobe
	input  wire logic                    i_rd,           // Read strobe
	output logic      [7:0]              o_rdata,        // Read data, cycle after i_rd
	input  wire sleep_wake_pkg::cpu_cmd_s i_cmd,         // Decoded sleep/watchdog opcodes
	input  wire logic                    i_power_good,   // Supply good, async
	input  wire logic                    i_ext_resetn,   // External reset pin, async
	input  wire logic [3:0]              i_wake_pin,     // Wake pins a..d, async
	input  wire logic [7:0]              i_port2,        // Port-2 pins, async
	input  wire logic [1:0]              i_timer_irq,    // Counter/timer requests
	input  wire logic                    i_lvd,          // Low-voltage detect, async
	output logic                         o_cpu_clk_en,   // CPU core clock gate
	output logic                         o_xtal_en,      // Crystal oscillator enable
	output logic                         o_cpu_reset,    // CPU held in reset
	output logic      [15:0]             o_restart_addr, // Restart vector
	output sleep_wake_pkg::cpu_flags_s   o_cpu_flags,    // Flag update from watchdog op
	output logic      [5:0]              o_irq_req,      // Enabled requests to CPU
	output logic                         o_irq,          // Summary interrupt, level
	output logic                         o_wake_async    // Unclocked wake for clock restart
);
	localparam int unsigned HOLD_CYC = `SW_RECOV_HOLD_TPC * `SW_TPC_MCLKS;
	localparam int unsigned WIN_CYC  = `SW_WDT_WINDOW_TPC * `SW_TPC_MCLKS;

	sleep_wake_pkg::power_state_e state;
	sleep_wake_pkg::power_state_e next_state;

	// Two-flop synchroniser: {lvd, ext_resetn, power_good, port2, wake pins}
	logic [14:0] sync1;
	logic [14:0] sync2;
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			// External reset stage idles high, so no false reset follows release
			sync1 <= 15'h2000;
			sync2 <= 15'h2000;
		end else begin
			sync1 <= {i_lvd, i_ext_resetn, i_power_good, i_port2, i_wake_pin};
			sync2 <= sync1;
		end
	end

	wire [3:0] wake_s  = sync2[3:0];
	wire [7:0] port2_s = sync2[11:4];
	wire       pg      = sync2[12];
	wire       ext_rst = ~sync2[13];
	wire       lvd_s   = sync2[14];

	// Registers
	logic [7:0] recov_ctrl;
	logic [3:0] wdt_cfg;
	logic [7:0] port3_mode;
	logic [7:0] port2_dir;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic       irq_global;
	logic       warm;
	logic       pg_d;
	logic       win_open;
	logic [7:0] win_cnt;
	logic [3:0] hold_cnt;
	logic [POR_CNT_W-1:0] por_cnt;

	wire [2:0] src_sel   = recov_ctrl[`SW_RECOV_SRC_LSB+2:`SW_RECOV_SRC_LSB];
	wire       delay_sel = recov_ctrl[`SW_RECOV_DELAY_BIT];
	wire       pol       = recov_ctrl[`SW_RECOV_POL_BIT];
	wire       pg_rise   = pg & ~pg_d;

	// Recovery source selection
	wire [7:0] p2_eff    = port2_s & ~port2_dir;
	wire [7:0] p2_raw    = i_port2 & ~port2_dir;
	wire [7:0] src_vec   = {~|p2_eff, ~|p2_eff[3:0], wake_s, 2'b00};
	wire [7:0] raw_vec   = {~|p2_raw, ~|p2_raw[3:0], i_wake_pin, 2'b00};
	wire       src_valid = src_sel[2] | src_sel[1];
	wire       wake_level = src_valid & (src_vec[src_sel] == pol);
	wire       in_stop   = (state == sleep_wake_pkg::ST_STOP);
	wire       recov_hit = in_stop & wake_level
	                     & (hold_cnt == 4'(HOLD_CYC - 1));

	// Async path reaches the oscillator even while every clock is stopped
	assign o_wake_async = in_stop & src_valid & (raw_vec[src_sel] == pol);

	// Watchdog
	wire wdt_to;
	wire wdt_en;
	wire in_run  = (state == sleep_wake_pkg::ST_RUN);
	wire in_halt = (state == sleep_wake_pkg::ST_HALT);
	wire in_por  = (state == sleep_wake_pkg::ST_POR_WAIT);
	wire wdt_run = in_run | (in_halt & wdt_cfg[`SW_WDT_HALT_BIT])
	             | (in_stop & wdt_cfg[`SW_WDT_STOP_BIT]);
	// A core held in reset executes nothing, so its opcode cannot arm the watchdog
	wire wdt_kick = in_run & i_cmd.wdt & ~ext_rst;

	sleep_wake_watchdog #(
		.BASE_CYCLES (WDT_BASE),
		.CNT_W       (24)
	) u_wdt (
		.i_mclk    (i_mclk),
		.i_resetn  (i_resetn),
		.i_clear   (in_por | ext_rst),
		.i_kick    (wdt_kick),
		.i_run     (wdt_run),
		.i_tap     (wdt_cfg[1:0]),
		.o_enabled (wdt_en),
		.o_timeout (wdt_to)
	);

	// Interrupt sources
	wire       irq2_src = port3_mode[`SW_P3M_ANALOG_BIT] ? wake_level : wake_s[2];
	wire [5:0] irq_raw  = {lvd_s, i_timer_irq, irq2_src, wake_s[1], wake_s[0]};
	wire [7:0] irq_evt  = {recov_hit, wdt_to, irq_raw};
	assign o_irq_req = irq_status[5:0] & irq_mask[5:0] & {6{irq_global}};
	assign o_irq     = irq_global & |(irq_status & irq_mask);

	// Power state sequencing
	wire por_done = in_por & (por_cnt == POR_CNT_W'(POR_CYCLES - 1));
	always_comb begin
		next_state = state;
		if (!pg || wdt_to) begin
			next_state = sleep_wake_pkg::ST_POR_WAIT;
		end else begin
			unique case (state)
				sleep_wake_pkg::ST_POR_WAIT: begin
					if (por_done) next_state = sleep_wake_pkg::ST_RUN;
				end
				sleep_wake_pkg::ST_RUN: begin
					// Callers flush the pipeline with a no-op first
					if (ext_rst) next_state = sleep_wake_pkg::ST_RUN;
					else if (i_cmd.stop) next_state = sleep_wake_pkg::ST_STOP;
					else if (i_cmd.halt) next_state = sleep_wake_pkg::ST_HALT;
				end
				sleep_wake_pkg::ST_HALT: begin
					if (ext_rst || |o_irq_req) next_state = sleep_wake_pkg::ST_RUN;
				end
				sleep_wake_pkg::ST_STOP: begin
					if (ext_rst) next_state = sleep_wake_pkg::ST_RUN;
					else if (recov_hit) begin
						next_state = delay_sel ? sleep_wake_pkg::ST_POR_WAIT
						                       : sleep_wake_pkg::ST_RUN;
					end
				end
			endcase
		end
	end

	wire fast_recov = in_stop & recov_hit & ~delay_sel & pg & ~wdt_to & ~ext_rst;
	wire por_start  = (next_state == sleep_wake_pkg::ST_POR_WAIT) & ~in_por;
	wire next_reset = (next_state == sleep_wake_pkg::ST_POR_WAIT) | ext_rst | fast_recov;
	wire win_start  = por_done | fast_recov;

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			state        <= sleep_wake_pkg::ST_POR_WAIT;
			pg_d         <= 1'b0;
			o_cpu_clk_en <= 1'b0;
			o_xtal_en    <= 1'b1;
			o_cpu_reset  <= 1'b1;
		end else begin
			state        <= next_state;
			pg_d         <= pg;
			o_cpu_clk_en <= (next_state == sleep_wake_pkg::ST_RUN);
			o_xtal_en    <= (next_state != sleep_wake_pkg::ST_STOP);
			o_cpu_reset  <= next_reset;
		end
	end

	// Delay, hold and window counters
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			por_cnt  <= '0;
			hold_cnt <= 4'h0;
			win_open <= 1'b0;
			win_cnt  <= 8'h00;
		end else begin
			por_cnt  <= (por_start || !pg || !in_por) ? '0 : por_cnt + POR_CNT_W'(1);
			hold_cnt <= (in_stop && wake_level && !recov_hit) ? hold_cnt + 4'h1 : 4'h0;
			if (win_start) begin
				win_open <= 1'b1;
				win_cnt  <= 8'h00;
			end else if (win_open && in_run) begin
				win_cnt  <= win_cnt + 8'h01;
				win_open <= (win_cnt != 8'(WIN_CYC - 1));
			end
		end
	end

	// Register decode
	wire wr_recov  = i_wr & (i_addr == `SW_ADDR_RECOV_CTRL);
	wire wr_wdt    = i_wr & (i_addr == `SW_ADDR_WDT_CFG) & win_open;
	wire wr_p3m    = i_wr & (i_addr == `SW_ADDR_PORT3_MODE);
	wire wr_p2dir  = i_wr & (i_addr == `SW_ADDR_PORT2_DIR);
	wire wr_status = i_wr & (i_addr == `SW_ADDR_IRQ_STATUS);
	wire wr_mask   = i_wr & (i_addr == `SW_ADDR_IRQ_MASK);
	wire wr_global = i_wr & (i_addr == `SW_ADDR_IRQ_GLOBAL);

	wire [7:0] recov_view = {warm, recov_ctrl[6:0]};
	wire [7:0] next_rdata =
		(i_addr == `SW_ADDR_RECOV_CTRL) ? recov_view :
		(i_addr == `SW_ADDR_PORT3_MODE) ? port3_mode :
		(i_addr == `SW_ADDR_PORT2_DIR)  ? port2_dir  :
		(i_addr == `SW_ADDR_IRQ_STATUS) ? irq_status :
		(i_addr == `SW_ADDR_IRQ_MASK)   ? irq_mask   :
		(i_addr == `SW_ADDR_IRQ_GLOBAL) ? {7'h00, irq_global} : 8'h00; // watchdog config unreadable

	// Set wins over a write-one clear in the same cycle
	wire [7:0] next_status = (irq_status & ~({8{wr_status}} & i_wdata)) | irq_evt;

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			recov_ctrl <= `SW_RST_RECOV_CTRL;
			wdt_cfg    <= `SW_RST_WDT_CFG;
			port3_mode <= 8'h00;
			port2_dir  <= 8'h00;
			irq_status <= 8'h00;
			irq_mask   <= 8'h00;
			irq_global <= 1'b0;
			o_rdata    <= 8'h00;
		end else begin
			o_rdata    <= i_rd ? next_rdata : 8'h00;
			irq_status <= next_status;
			if (pg_rise) begin
				recov_ctrl <= `SW_RST_RECOV_CTRL;
			end else if (wr_recov) begin
				recov_ctrl <= {1'b0, i_wdata[6:0]};
			end
			if (wr_wdt) wdt_cfg <= i_wdata[3:0];
			if (wr_p3m) port3_mode <= i_wdata;
			if (wr_p2dir) port2_dir <= i_wdata;
			if (wr_mask) irq_mask <= i_wdata;
			if (wr_global) irq_global <= i_wdata[0];
		end
	end

	// Cold/warm flag and watchdog flag update
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			warm           <= 1'b0;
			o_cpu_flags    <= '0;
			o_restart_addr <= `SW_RESTART_ADDR;
		end else begin
			if (in_stop && recov_hit && pg && !wdt_to && !ext_rst) warm <= 1'b1;
			else if (por_start || ext_rst) warm <= 1'b0;
			o_cpu_flags.we <= wdt_kick;
			o_cpu_flags.z  <= wdt_kick;
			o_cpu_flags.s  <= 1'b0;
			o_cpu_flags.v  <= 1'b0;
			o_restart_addr <= `SW_RESTART_ADDR;
		end
	end

	AST_POR_HOLD: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		in_por |-> o_cpu_reset && !o_cpu_clk_en)
		else $error("CPU released during power-on delay");

	AST_POR_COUNT: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		in_por && pg && !wdt_to && (por_cnt < POR_CNT_W'(POR_CYCLES - 1)) |=> in_por)
		else $error("Power-on delay ended early");

	AST_WDT_POR: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		wdt_to |=> in_por && por_cnt == '0 && o_cpu_reset)
		else $error("Watchdog timeout did not start power-on delay");

	AST_HALT_CLK: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		in_run && i_cmd.halt && !i_cmd.stop && pg && !wdt_to && !ext_rst
		|=> in_halt && !o_cpu_clk_en && o_xtal_en)
		else $error("Light sleep clock gating wrong");

	AST_HALT_EXIT: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		in_halt && o_irq_req == 6'h00 && pg && !wdt_to && !ext_rst |=> in_halt)
		else $error("Left light sleep without an enabled request");

	AST_STOP_CLK: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		in_stop |-> !o_xtal_en && !o_cpu_clk_en)
		else $error("Clock running in deep sleep");

	AST_FAST_WAKE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		fast_recov |-> $past(wake_level, 9) ##1 (in_run && o_cpu_reset && warm))
		else $error("Fast recovery held too short or not taken");

	AST_SLOW_WAKE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		in_stop && recov_hit && delay_sel && pg && !wdt_to && !ext_rst |=> in_por && warm)
		else $error("Delayed recovery skipped power-on delay");

	AST_WDT_LOCK: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		!win_open && !win_start |=> $stable(wdt_cfg))
		else $error("Watchdog config changed outside window");

	AST_IRQ2_SRC: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		port3_mode[`SW_P3M_ANALOG_BIT] && wake_level |=> irq_status[2])
		else $error("Recovery logic did not reach interrupt");

	AST_WDT_FLAGS: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		wdt_kick |=> o_cpu_flags.we && wdt_en)
		else $error("Watchdog instruction lost");

	AST_HALT_OSC: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		in_halt |-> o_xtal_en && !o_cpu_clk_en)
		else $error("Oscillator or core clock wrong in light sleep");

	AST_POL_RESET: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		pg_rise |=> !pol && delay_sel)
		else $error("Recovery control defaults not reloaded at power-up");

	AST_COLD_START: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		por_start && !in_stop |=> !warm)
		else $error("Warm flag left set after a cold start");

	AST_WDT_ARMED: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		wdt_to |-> $past(wdt_en))
		else $error("Watchdog timed out while disarmed");

	AST_WIN_LEN: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		win_open |-> win_cnt < 8'(WIN_CYC))
		else $error("Watchdog config window overran its length");

endmodule : sleep_wake_reset_watchdog
`default_nettype wire

// *** logic/sleep_wake_defs.svh ***
// Register offsets, field positions, reset values and timing counts of the sleep/wake block
`ifndef SLEEP_WAKE_DEFS_SVH
`define SLEEP_WAKE_DEFS_SVH

`define SW_ADDR_PORT3_MODE   8'h03
`define SW_ADDR_PORT2_DIR    8'h06
`define SW_ADDR_RECOV_CTRL   8'h0B
`define SW_ADDR_WDT_CFG      8'h0F
`define SW_ADDR_IRQ_STATUS   8'h10
`define SW_ADDR_IRQ_MASK     8'h11
`define SW_ADDR_IRQ_GLOBAL   8'h12

`define SW_RECOV_SRC_LSB     2
`define SW_RECOV_DELAY_BIT   5
`define SW_RECOV_POL_BIT     6
`define SW_RECOV_WARM_BIT    7
`define SW_WDT_HALT_BIT      2
`define SW_WDT_STOP_BIT      3
`define SW_P3M_ANALOG_BIT    1
`define SW_IRQ_WDT_BIT       6
`define SW_IRQ_RECOV_BIT     7

`define SW_RST_RECOV_CTRL    8'h20
`define SW_RST_WDT_CFG       4'h0
`define SW_RESTART_ADDR      16'h000C

`define SW_MCLK_MHZ          250
`define SW_TPC_MCLKS         2
`define SW_POR_DELAY_US      2500
`define SW_RECOV_HOLD_TPC    5
`define SW_WDT_WINDOW_TPC    60
`define SW_WDT_BASE_CYCLES   1250000

`endif

// *** logic/sleep_wake_pkg.sv ***
// Types shared by the sleep/wake block
package sleep_wake_pkg;

	typedef enum logic [3:0] {
		ST_POR_WAIT = 4'b0001,
		ST_RUN      = 4'b0010,
		ST_HALT     = 4'b0100,
		ST_STOP     = 4'b1000
	} power_state_e;

	typedef struct packed {
		logic stop;
		logic halt;
		logic wdt;
	} cpu_cmd_s;

	typedef struct packed {
		logic z;
		logic s;
		logic v;
		logic we;
	} cpu_flags_s;

endpackage : sleep_wake_pkg

// *** logic/sleep_wake_watchdog.sv ***
// Retriggerable watchdog one-shot with a tap-selected terminal count
`timescale 1ns/100ps
`default_nettype none
module sleep_wake_watchdog #(
	parameter int unsigned BASE_CYCLES = 1250000,
	parameter int unsigned CNT_W       = 24
) (
	input  wire logic       i_mclk,    // System clock
	input  wire logic       i_resetn,  // Async reset, active low
	input  wire logic       i_clear,   // Disable and zero the count
	input  wire logic       i_kick,    // Watchdog instruction
	input  wire logic       i_run,     // Counting allowed in this power state
	input  wire logic [1:0] i_tap,     // Timeout tap
	output logic            o_enabled, // Armed by first instruction
	output logic            o_timeout  // One-cycle terminal count pulse
);
	logic [CNT_W-1:0] count;
	wire  [CNT_W-1:0] terminal;
	wire              hit;
	wire  [CNT_W-1:0] next_count;
	wire              next_enabled;

	assign terminal     = CNT_W'(BASE_CYCLES) << i_tap;
	assign hit          = o_enabled & i_run & ~i_kick & ~i_clear
	                    & (count == terminal - CNT_W'(1));
	assign next_enabled = ~i_clear & (o_enabled | i_kick);
	assign next_count   = (i_clear | i_kick | hit) ? '0
	                    : (o_enabled & i_run) ? count + CNT_W'(1) : count;

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_enabled <= 1'b0;
			count     <= '0;
			o_timeout <= 1'b0;
		end else begin
			o_enabled <= next_enabled;
			count     <= next_count;
			o_timeout <= hit;
		end
	end
endmodule : sleep_wake_watchdog
`default_nettype wire

// *** test/cpu_stub.sv ***
// Behavioural CPU instruction stream that issues sleep and watchdog opcodes
`timescale 1ns/100ps
`default_nettype none
module cpu_stub #(
	parameter logic [7:0] WDT_OP = 8'h5F // Watchdog opcode, value arbitrary
) (
	input  wire logic                    i_mclk, // System clock
	input  wire logic                    i_go,   // Fetch the opcode below
	input  wire logic [7:0]              i_op,   // Opcode
	input  wire logic                    i_run,  // Core clock running
	output var sleep_wake_pkg::cpu_cmd_s o_cmd   // Decoded command pulse
);
	logic last_nop;
	initial begin
		last_nop = 1'b0;
		o_cmd = '0;
	end
	// A gated core fetches nothing; a sleep opcode needs a no-op just before it
	always @(posedge i_mclk) begin
		o_cmd <= '0;
		if (i_go && i_run) begin
			last_nop <= (i_op == 8'hFF);
			o_cmd.stop <= (i_op == 8'h6F) && last_nop;
			o_cmd.halt <= (i_op == 8'h7F) && last_nop;
			o_cmd.wdt <= (i_op == WDT_OP);
		end
	end
endmodule : cpu_stub
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the sleep/wake, recovery and watchdog block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int         POR = 50;
	localparam logic [7:0] WDT_OP = 8'h5F; // Arbitrary watchdog opcode
	logic                       i_mclk;
	logic                       i_resetn = 1'b0;
	logic [7:0]                 i_addr = 8'h00;
	logic [7:0]                 i_wdata = 8'h00;
	logic                       i_wr = 1'b0;
	logic                       i_rd = 1'b0;
	logic [7:0]                 o_rdata;
	sleep_wake_pkg::cpu_cmd_s   i_cmd;
	logic                       i_power_good = 1'b1;
	logic                       i_ext_resetn = 1'b1;
	logic [3:0]                 i_wake_pin = 4'h0;
	logic [7:0]                 i_port2 = 8'hFF;
	logic [1:0]                 i_timer_irq = 2'b00;
	logic                       i_lvd = 1'b0;
	logic                       o_cpu_clk_en;
	logic                       o_xtal_en;
	logic                       o_cpu_reset;
	logic [15:0]                o_restart_addr;
	sleep_wake_pkg::cpu_flags_s o_cpu_flags;
	logic [5:0]                 o_irq_req;
	logic                       o_irq;
	logic                       o_wake_async;
	logic                       cpu_go = 1'b0;
	logic [7:0]                 cpu_op = 8'h00;
	int                         miscompares = 0;
	int                         samples_checked = 0;
	int                         cycles = 0;
	int                         n;
	logic [7:0]                 v;

	sleep_wake_reset_watchdog #(.POR_CYCLES(POR), .WDT_BASE(64), .POR_CNT_W(20)) DUT (
		.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmd(i_cmd),
		.i_power_good(i_power_good), .i_ext_resetn(i_ext_resetn), .i_wake_pin(i_wake_pin),
		.i_port2(i_port2), .i_timer_irq(i_timer_irq), .i_lvd(i_lvd),
		.o_cpu_clk_en(o_cpu_clk_en), .o_xtal_en(o_xtal_en), .o_cpu_reset(o_cpu_reset),
		.o_restart_addr(o_restart_addr), .o_cpu_flags(o_cpu_flags), .o_irq_req(o_irq_req),
		.o_irq(o_irq), .o_wake_async(o_wake_async));

	cpu_stub #(.WDT_OP(WDT_OP)) cpu (.i_mclk(i_mclk), .i_go(cpu_go), .i_op(cpu_op),
		.i_run(o_cpu_clk_en), .o_cmd(i_cmd));

	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end

	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish;
		end
	end

	// Drives are non-blocking at the edge; reads see the values from before it
	task tick(input int k);
		repeat (k) @(posedge i_mclk);
	endtask : tick

	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask : chk

	task tally_and_finish;
		$display("checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	task wr(input logic [7:0] a, input logic [7:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		tick(1);
		i_wr <= 1'b0;
		tick(1);
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] d);
		i_rd <= 1'b1;
		i_addr <= a;
		tick(1);
		i_rd <= 1'b0;
		tick(1);
		d = o_rdata;
	endtask : rd

	// Flags from a watchdog op are caught within four cycles
	task op(input logic [7:0] code);
		sleep_wake_pkg::cpu_flags_s f;
		f = '0;
		cpu_go <= 1'b1;
		cpu_op <= code;
		tick(1);
		cpu_go <= 1'b0;
		repeat (4) begin
			tick(1);
			if (o_cpu_flags.we === 1'b1) f = o_cpu_flags;
		end
		if (code == WDT_OP) chk(16'(f), 16'h0009);
	endtask : op

	task wait_for(input logic sel, input logic want, input int lim, output int k);
		k = 0;
		while ((sel ? o_cpu_reset : o_cpu_clk_en) !== want && k < lim) begin
			tick(1);
			k++;
		end
		chk(16'(sel ? o_cpu_reset : o_cpu_clk_en), 16'(want));
	endtask : wait_for

	task t_por_regs;
		tick(3);
		chk(16'({o_cpu_reset, o_cpu_clk_en, o_xtal_en}), 16'h0005);
		chk(o_restart_addr, 16'h000C);
		i_resetn <= 1'b1;
		wait_for(1'b0, 1'b1, 200, n);
		chk(16'(n >= POR), 16'h0001);
		wr(8'h0F, 8'h01);
		rd(8'h0F, v);
		chk(16'(v), 16'h0000);
		rd(8'h0B, v);
		chk(16'(v), 16'h0020);
		wr(8'h0B, 8'hFF);
		rd(8'h0B, v);
		chk(16'(v), 16'h007F);
		wr(8'h0B, 8'h20);
		rd(8'h20, v);
		chk(16'(v), 16'h0000);
	endtask : t_por_regs

	// Late config write must not shorten the tap chosen in the window
	task t_watchdog;
		tick(130);
		wr(8'h0F, 8'h00);
		op(WDT_OP);
		repeat (2) begin
			tick(85);
			op(WDT_OP);
			chk(16'(o_cpu_reset), 16'h0000);
		end
		wait_for(1'b1, 1'b1, 200, n);
		chk(16'(n >= 115 && n <= 135), 16'h0001);
		wait_for(1'b0, 1'b1, 200, n);
		chk(16'(n >= POR - 1), 16'h0001);
		rd(8'h10, v);
		chk(16'(v), 16'h0040);
		wr(8'h10, 8'h40);
		rd(8'h0B, v);
		chk(16'(v), 16'h0020);
	endtask : t_watchdog

	task t_halt;
		wr(8'h11, 8'h01);
		wr(8'h12, 8'h01);
		op(8'hFF);
		op(8'h7F);
		chk(16'({o_cpu_clk_en, o_xtal_en}), 16'h0001);
		i_timer_irq <= 2'b01;
		tick(10);
		chk(16'({o_cpu_clk_en, o_irq}), 16'h0000);
		i_wake_pin <= 4'h1;
		wait_for(1'b0, 1'b1, 20, n);
		chk(16'({o_irq, o_irq_req}), 16'h0041);
		i_wake_pin <= 4'h0;
		i_timer_irq <= 2'b00;
		tick(4);
		wr(8'h10, 8'hFF);
		chk(16'(o_irq), 16'h0000);
		op(8'hFF);
		op(8'h7F);
		i_ext_resetn <= 1'b0;
		tick(4);
		chk(16'(o_cpu_reset), 16'h0001);
		i_ext_resetn <= 1'b1;
		wait_for(1'b0, 1'b1, 20, n);
		wr(8'h11, 8'h00);
	endtask : t_halt

	task t_irq_source;
		wr(8'h0B, 8'h68);
		for (int m = 0; m < 2; m++) begin
			wr(8'h03, 8'(m << 1));
			i_wake_pin <= 4'h1;
			i_lvd <= 1'b1;
			tick(6);
			rd(8'h10, v);
			chk(16'(v[5:0]), (m == 1) ? 16'h0025 : 16'h0021);
			i_wake_pin <= 4'h0;
			i_lvd <= 1'b0;
			tick(6);
			wr(8'h10, 8'hFF);
		end
		wr(8'h03, 8'h00);
	endtask : t_irq_source

	task t_stop(input logic [2:0] src, input logic pol, input logic dly, input logic [3:0] pidle,
		input logic [3:0] pact, input logic [7:0] p2act, input logic shrt);
		i_wake_pin <= pidle;
		wr(8'h0B, {1'b0, pol, dly, src, 2'b00});
		op(8'hFF);
		op(8'h6F);
		chk(16'({o_cpu_clk_en, o_xtal_en}), 16'h0000);
		if (shrt) begin
			i_wake_pin <= pact;
			i_port2 <= p2act;
			tick(3);
			i_wake_pin <= pidle;
			i_port2 <= 8'hFF;
			tick(30);
			chk(16'(o_cpu_clk_en), 16'h0000);
		end
		i_wake_pin <= pact;
		i_port2 <= p2act;
		tick(1);
		chk(16'(o_wake_async), 16'h0001);
		wait_for(1'b0, 1'b1, 120, n);
		chk(16'(dly ? n >= POR - 1 : n <= 30), 16'h0001);
		i_wake_pin <= pidle;
		i_port2 <= 8'hFF;
		rd(8'h0B, v);
		chk(16'(v), 16'({1'b1, pol, dly, src, 2'b00}));
		chk(o_restart_addr, 16'h000C);
		tick(4);
		wr(8'h10, 8'hFF);
	endtask : t_stop

	initial begin
		t_por_regs;
		t_watchdog;
		t_halt;
		t_irq_source;
		t_stop(3'b010, 1'b1, 1'b0, 4'h0, 4'h1, 8'hFF, 1'b1);
		t_stop(3'b011, 1'b1, 1'b0, 4'h0, 4'h2, 8'hFF, 1'b0);
		t_stop(3'b100, 1'b1, 1'b0, 4'h0, 4'h4, 8'hFF, 1'b0);
		t_stop(3'b101, 1'b1, 1'b0, 4'h0, 4'h8, 8'hFF, 1'b0);
		t_stop(3'b110, 1'b1, 1'b0, 4'h0, 4'h0, 8'hF0, 1'b0);
		wr(8'h06, 8'h80);
		t_stop(3'b111, 1'b1, 1'b0, 4'h0, 4'h0, 8'h80, 1'b0);
		wr(8'h06, 8'h00);
		t_stop(3'b010, 1'b0, 1'b0, 4'h1, 4'h0, 8'hFF, 1'b0);
		t_stop(3'b010, 1'b1, 1'b1, 4'h0, 4'h1, 8'hFF, 1'b0);
		tally_and_finish;
	end
endmodule : tb_top
`default_nettype wire
